// >>> sensor_timing.sv
`timescale 1ns/1ps

// Overview of operation
// - Integration of next frame overlaps current readout
// - Integration spans reset fall to sample rise
// - Readout starts after boost returns high
// - Row sync loads row start times two
// - Row step advances; sync overrides immediately
// - One output: two pixels per clock
// - Two outputs: one pixel each per clock
// - First column is start times two, 2048
// - Column sync plus clock rise starts pixels
// - Primary reset dominates secondary reset
// - Memory node follows boost control level
// - Start registers are ten bits, even starts
module sensor_timing (
	input  wire logic                                CLK_I,
	input  wire logic                                RESETN_I,
	input  wire sensor_timing_pkg::pixel_pins_t      PIXEL_I,
	input  wire sensor_timing_pkg::readout_pins_t    READOUT_I,
	input  wire sensor_timing_pkg::config_pins_t     CONFIG_I,
	output logic                                     MEM_NODE_HIGH_O,
	output logic [1:0]                               RESET_LEVEL_O,
	output logic                                     INTEGRATING_O,
	output logic [sensor_timing_pkg::CNT_W-1:0]      INTEG_CYCLES_O,
	output logic [sensor_timing_pkg::CNT_W-1:0]      FRAME_OVERHEAD_CYCLES_O,
	output logic                                     READOUT_ACTIVE_O,
	output logic [sensor_timing_pkg::ROW_W-1:0]      ROW_ADDR_O,
	output logic                                     NEW_LINE_O,
	output logic                                     COL_PRECHARGE_O,
	output logic [sensor_timing_pkg::COL_W-1:0]      PIX1_ADDR_O,
	output logic [sensor_timing_pkg::COL_W-1:0]      PIX2_ADDR_O,
	output logic                                     PIX1_STB_O,
	output logic                                     PIX2_STB_O,
	output logic                                     LINE_DONE_O
);

	logic [sensor_timing_pkg::PINS_W-1:0] raw;
	logic [sensor_timing_pkg::PINS_W-1:0] s1_r;
	logic [sensor_timing_pkg::PINS_W-1:0] s2_r;
	logic [sensor_timing_pkg::PINS_W-1:0] s3_r;
	logic [sensor_timing_pkg::PINS_W-1:0] filt_r;
	sensor_timing_pkg::pins_t             pin;
	sensor_timing_pkg::pins_t             prev_r;

	logic                                 reset_fall;
	logic                                 sample_rise;
	logic                                 boost_fall;
	logic                                 boost_rise;
	logic                                 clk_y_rise;
	logic                                 clk_x_rise;
	logic                                 clk_x_fall;
	logic [sensor_timing_pkg::CNT_W-1:0]  integ_cnt_r;
	logic [sensor_timing_pkg::CNT_W-1:0]  overhead_cnt_r;
	logic                                 overhead_run_r;
	logic [sensor_timing_pkg::COL_W-1:0]  col_r;
	logic [sensor_timing_pkg::COL_W-1:0]  col_first;
	logic [sensor_timing_pkg::ROW_W-1:0]  row_first;
	sensor_timing_pkg::col_state_t        col_state_r;

	assign raw = {PIXEL_I, READOUT_I, CONFIG_I};

	// Each pin bit passes three flops and only changes once stages two and three agree.
	generate
		for (genvar b = 0; b < sensor_timing_pkg::PINS_W; b++) begin : g_sync
			always_ff @(posedge CLK_I or negedge RESETN_I) begin
				if (!RESETN_I) begin
					s1_r[b]   <= 1'b0;
					s2_r[b]   <= 1'b0;
					s3_r[b]   <= 1'b0;
					filt_r[b] <= 1'b0;
				end else begin
					s1_r[b] <= raw[b];
					s2_r[b] <= s1_r[b];
					s3_r[b] <= s2_r[b];
					if (s2_r[b] == s3_r[b]) begin
						filt_r[b] <= s3_r[b];
					end
				end
			end
		end
	endgenerate

	assign pin = sensor_timing_pkg::pins_t'(filt_r);

	// Previous filtered levels for edge detection.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			prev_r <= '0;
		end else begin
			prev_r <= pin;
		end
	end

	// Sample and boost are active low, so their assertion is a falling pin.
	assign reset_fall  = prev_r.pix.reset && !pin.pix.reset;
	assign sample_rise = prev_r.pix.sample_n && !pin.pix.sample_n;
	assign boost_fall  = prev_r.pix.memory_boost_ctl_n && !pin.pix.memory_boost_ctl_n;
	assign boost_rise  = !prev_r.pix.memory_boost_ctl_n && pin.pix.memory_boost_ctl_n;
	assign clk_y_rise  = !prev_r.rd.clock_y && pin.rd.clock_y;
	assign clk_x_rise  = !prev_r.rd.clock_x && pin.rd.clock_x;
	assign clk_x_fall  = prev_r.rd.clock_x && !pin.rd.clock_x;
	assign row_first   = {pin.cfg.row_start, 1'b0};
	assign col_first   = {1'b0, pin.cfg.col_start, 1'b0};

	// Memory node level and the reset level applied to the photodiodes.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			MEM_NODE_HIGH_O <= 1'b0;
			RESET_LEVEL_O   <= sensor_timing_pkg::RST_LVL_NONE;
		end else begin
			MEM_NODE_HIGH_O <= pin.pix.memory_boost_ctl_n;
			if (pin.pix.reset) begin
				RESET_LEVEL_O <= sensor_timing_pkg::RST_LVL_PRIMARY;
			end else if (pin.pix.secondary_reset_ctl) begin
				RESET_LEVEL_O <= sensor_timing_pkg::RST_LVL_SECONDARY;
			end else begin
				RESET_LEVEL_O <= sensor_timing_pkg::RST_LVL_NONE;
			end
		end
	end

	// Integration runs from reset fall to sample assertion, independent of readout.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			INTEGRATING_O  <= 1'b0;
			integ_cnt_r    <= sensor_timing_pkg::CNT_ZERO;
			INTEG_CYCLES_O <= sensor_timing_pkg::CNT_ZERO;
		end else begin
			if (sample_rise && INTEGRATING_O) begin
				INTEGRATING_O  <= 1'b0;
				INTEG_CYCLES_O <= integ_cnt_r;
			end else if (reset_fall) begin
				INTEGRATING_O <= 1'b1;
				integ_cnt_r   <= sensor_timing_pkg::CNT_ONE; // The edge cycle itself counts.
			end else if (INTEGRATING_O && pin.pix.reset) begin
				INTEGRATING_O <= 1'b0;
			end else if (INTEGRATING_O && integ_cnt_r != sensor_timing_pkg::CNT_MAX) begin
				integ_cnt_r <= integ_cnt_r + sensor_timing_pkg::CNT_ONE;
			end
		end
	end

	// Frame overhead is the boost low period; readout opens when boost returns high.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			overhead_run_r          <= 1'b0;
			overhead_cnt_r          <= sensor_timing_pkg::CNT_ZERO;
			FRAME_OVERHEAD_CYCLES_O <= sensor_timing_pkg::CNT_ZERO;
			READOUT_ACTIVE_O        <= 1'b0;
		end else begin
			if (boost_fall) begin
				overhead_run_r   <= 1'b1;
				overhead_cnt_r   <= sensor_timing_pkg::CNT_ONE; // The edge cycle itself counts.
				READOUT_ACTIVE_O <= 1'b0;
			end else if (boost_rise && overhead_run_r) begin
				overhead_run_r          <= 1'b0;
				FRAME_OVERHEAD_CYCLES_O <= overhead_cnt_r;
				READOUT_ACTIVE_O        <= 1'b1;
			end else if (overhead_run_r && overhead_cnt_r != sensor_timing_pkg::CNT_MAX) begin
				overhead_cnt_r <= overhead_cnt_r + sensor_timing_pkg::CNT_ONE;
			end
		end
	end

	// Row addressing: sync holds the start row, a step clock edge selects the next.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ROW_ADDR_O <= sensor_timing_pkg::ROW_ZERO;
			NEW_LINE_O <= 1'b0;
		end else begin
			NEW_LINE_O <= clk_y_rise;
			if (pin.rd.sync_y) begin
				ROW_ADDR_O <= row_first;
			end else if (clk_y_rise) begin
				ROW_ADDR_O <= ROW_ADDR_O + sensor_timing_pkg::ROW_STEP;
			end
		end
	end

	// Column buses are precharged while either row overhead control is active.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			COL_PRECHARGE_O <= 1'b0;
		end else begin
			COL_PRECHARGE_O <= pin.rd.norowsel || !pin.rd.pre_col_n;
		end
	end

	// Column readout: addresses hold the last pixel until a new line streams.
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			col_state_r <= sensor_timing_pkg::COL_IDLE;
			col_r       <= sensor_timing_pkg::COL_ZERO;
			PIX1_ADDR_O <= sensor_timing_pkg::COL_ZERO;
			PIX2_ADDR_O <= sensor_timing_pkg::COL_ZERO;
			PIX1_STB_O  <= 1'b0;
			PIX2_STB_O  <= 1'b0;
			LINE_DONE_O <= 1'b0;
		end else begin
			PIX1_STB_O  <= 1'b0;
			PIX2_STB_O  <= 1'b0;
			LINE_DONE_O <= 1'b0;
			if (clk_y_rise) begin
				col_state_r <= sensor_timing_pkg::COL_IDLE;
			end else if (clk_x_rise && pin.rd.sync_x) begin
				col_state_r <= sensor_timing_pkg::COL_STREAM;
				PIX1_ADDR_O <= col_first;
				PIX1_STB_O  <= 1'b1;
				if (pin.cfg.dual_output) begin
					PIX2_ADDR_O <= col_first + sensor_timing_pkg::COL_NEXT;
					PIX2_STB_O  <= 1'b1;
					col_r       <= col_first + sensor_timing_pkg::COL_PAIR;
				end else begin
					col_r <= col_first + sensor_timing_pkg::COL_NEXT;
				end
			end else begin
				unique case (col_state_r)
					sensor_timing_pkg::COL_IDLE: begin
					end
					sensor_timing_pkg::COL_STREAM: begin
						if (col_r >= sensor_timing_pkg::COL_LIMIT) begin
							col_state_r <= sensor_timing_pkg::COL_DONE;
							LINE_DONE_O <= 1'b1;
						end else if (pin.cfg.dual_output && clk_x_rise) begin
							PIX1_ADDR_O <= col_r;
							PIX2_ADDR_O <= col_r + sensor_timing_pkg::COL_NEXT;
							PIX1_STB_O  <= 1'b1;
							PIX2_STB_O  <= 1'b1;
							col_r       <= col_r + sensor_timing_pkg::COL_PAIR;
						end else if (!pin.cfg.dual_output && (clk_x_rise || clk_x_fall)) begin
							PIX1_ADDR_O <= col_r;
							PIX1_STB_O  <= 1'b1;
							col_r       <= col_r + sensor_timing_pkg::COL_NEXT;
						end
					end
					sensor_timing_pkg::COL_DONE: begin
					end
					default: begin
						col_state_r <= sensor_timing_pkg::COL_IDLE;
					end
				endcase
			end
		end
	end

endmodule : sensor_timing

// >>> sensor_timing_pkg.sv
package sensor_timing_pkg;

	// Widths of the start registers and of the line and column addresses.
	localparam int unsigned START_W    = 10;
	localparam int unsigned ROW_W      = 11;
	localparam int unsigned COL_W      = 12;
	localparam int unsigned CNT_W      = 24;

	// Pixels that a selected line makes available, and the column limit.
	localparam int unsigned PIXELS_PER_LINE = 2048;
	localparam logic [COL_W-1:0] COL_LIMIT  = 12'h800;
	localparam logic [COL_W-1:0] COL_PAIR   = 12'h002;
	localparam logic [COL_W-1:0] COL_NEXT   = 12'h001;
	localparam logic [ROW_W-1:0] ROW_STEP   = 11'h001;

	// Reset values of counters and addresses, counter step and ceiling.
	localparam logic [CNT_W-1:0] CNT_ZERO   = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_MAX    = 24'hffffff;
	localparam logic [CNT_W-1:0] CNT_ONE    = 24'h000001;
	localparam logic [ROW_W-1:0] ROW_ZERO   = 11'h000;
	localparam logic [COL_W-1:0] COL_ZERO   = 12'h000;

	// Codes of the pixel reset level applied to the array.
	localparam logic [1:0] RST_LVL_NONE      = 2'h0;
	localparam logic [1:0] RST_LVL_SECONDARY = 2'h1;
	localparam logic [1:0] RST_LVL_PRIMARY   = 2'h2;

	// Pixel array controls; the _n fields are active low at the pins.
	typedef struct packed {
		logic memory_boost_ctl_n;
		logic precharge_n;
		logic sample_n;
		logic reset;
		logic secondary_reset_ctl;
	} pixel_pins_t;

	// Readout addressing and row overhead controls.
	typedef struct packed {
		logic sync_y;
		logic clock_y;
		logic sync_x;
		logic clock_x;
		logic norowsel;
		logic pre_col_n;
		logic column_sample_hold_n;
	} readout_pins_t;

	// Window start values and output count from the configuration port.
	typedef struct packed {
		logic [START_W-1:0] row_start;
		logic [START_W-1:0] col_start;
		logic               dual_output;
	} config_pins_t;

	typedef struct packed {
		pixel_pins_t   pix;
		readout_pins_t rd;
		config_pins_t  cfg;
	} pins_t;

	localparam int unsigned PINS_W = $bits(pins_t);

	// Column readout states.
	typedef enum logic [2:0] {
		COL_IDLE   = 3'b001,
		COL_STREAM = 3'b010,
		COL_DONE   = 3'b100
	} col_state_t;

endpackage : sensor_timing_pkg

// >>> sensor_monitor.sv
`timescale 1ns/1ps
// Watches the timing block ports; pins reach outputs after five clock edges.
module sensor_monitor (
	input  wire logic                                CLK_I,
	input  wire logic                                RESETN_I,
	input  wire sensor_timing_pkg::pixel_pins_t      PIXEL_I,
	input  wire sensor_timing_pkg::readout_pins_t    READOUT_I,
	input  wire sensor_timing_pkg::config_pins_t     CONFIG_I,
	input  wire logic                                MEM_NODE_HIGH_O,
	input  wire logic [1:0]                          RESET_LEVEL_O,
	input  wire logic                                INTEGRATING_O,
	input  wire logic                                READOUT_ACTIVE_O,
	input  wire logic [sensor_timing_pkg::ROW_W-1:0] ROW_ADDR_O,
	input  wire logic                                NEW_LINE_O,
	input  wire logic                                COL_PRECHARGE_O,
	input  wire logic [sensor_timing_pkg::COL_W-1:0] PIX1_ADDR_O,
	input  wire logic [sensor_timing_pkg::COL_W-1:0] PIX2_ADDR_O,
	input  wire logic                                PIX1_STB_O,
	input  wire logic                                PIX2_STB_O,
	input  wire logic                                LINE_DONE_O
);
	// One clock domain, checks paused while reset is low.
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Multi-step causes.
	sequence s_quiet; !READOUT_I.sync_y[*8]; endsequence
	sequence s_rst_fall; $fell(PIXEL_I.reset) ##1 (!PIXEL_I.reset && PIXEL_I.sample_n)[*6]; endsequence
	property p_prim; PIXEL_I.reset[*7] |-> RESET_LEVEL_O == sensor_timing_pkg::RST_LVL_PRIMARY; endproperty
	a_prim: assert property (p_prim) else $error("primary level missing");
	property p_sec; (!PIXEL_I.reset && PIXEL_I.secondary_reset_ctl)[*7] |-> RESET_LEVEL_O == 2'h1; endproperty
	a_sec: assert property (p_sec) else $error("secondary level missing");
	property p_mem; PIXEL_I.memory_boost_ctl_n[*7] |-> MEM_NODE_HIGH_O; endproperty
	a_mem: assert property (p_mem) else $error("memory node not high");
	property p_act; $rose(READOUT_ACTIVE_O) |-> $past(PIXEL_I.memory_boost_ctl_n, 4); endproperty
	a_act: assert property (p_act) else $error("readout before boost release");
	property p_row; READOUT_I.sync_y[*7] |-> ROW_ADDR_O == {CONFIG_I.row_start, 1'b0}; endproperty
	a_row: assert property (p_row) else $error("row start wrong");
	property p_step; s_quiet ##0 NEW_LINE_O |-> ROW_ADDR_O == $past(ROW_ADDR_O) + 11'h001; endproperty
	a_step: assert property (p_step) else $error("row step wrong");
	property p_nl; $rose(READOUT_I.clock_y) |-> ##[3:6] NEW_LINE_O; endproperty
	a_nl: assert property (p_nl) else $error("new line missing");
	property p_pair; PIX1_STB_O && PIX2_STB_O |-> PIX2_ADDR_O == PIX1_ADDR_O + 12'h001 && !PIX1_ADDR_O[0]; endproperty
	a_pair: assert property (p_pair) else $error("pixel pair wrong");
	property p_single; PIX1_STB_O && !CONFIG_I.dual_output |-> !PIX2_STB_O; endproperty
	a_single: assert property (p_single) else $error("second output in single mode");
	property p_done; LINE_DONE_O |=> !LINE_DONE_O[*3]; endproperty
	a_done: assert property (p_done) else $error("line end repeated");
	property p_colpre; READOUT_I.norowsel[*7] |-> COL_PRECHARGE_O; endproperty
	a_colpre: assert property (p_colpre) else $error("column precharge missing");
	property p_int; s_rst_fall |-> INTEGRATING_O; endproperty
	a_int: assert property (p_int) else $error("integration not started");
endmodule : sensor_monitor

bind sensor_timing sensor_monitor i_mon (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .PIXEL_I(PIXEL_I),
	.READOUT_I(READOUT_I), .CONFIG_I(CONFIG_I), .MEM_NODE_HIGH_O(MEM_NODE_HIGH_O),
	.RESET_LEVEL_O(RESET_LEVEL_O), .INTEGRATING_O(INTEGRATING_O), .READOUT_ACTIVE_O(READOUT_ACTIVE_O),
	.ROW_ADDR_O(ROW_ADDR_O), .NEW_LINE_O(NEW_LINE_O), .COL_PRECHARGE_O(COL_PRECHARGE_O),
	.PIX1_ADDR_O(PIX1_ADDR_O), .PIX2_ADDR_O(PIX2_ADDR_O), .PIX1_STB_O(PIX1_STB_O),
	.PIX2_STB_O(PIX2_STB_O), .LINE_DONE_O(LINE_DONE_O));

// >>> ctrl_model.sv
`timescale 1ns/1ps
// Controller model: one integration and frame overhead while go is high.
module ctrl_model #(
	parameter int INTEG = 300
) (
	input  wire logic                      clk_i,
	input  wire logic                      go_i,
	output sensor_timing_pkg::pixel_pins_t pix_o
);
	localparam int B = 30 + INTEG;
	int t;
	// Step counter, cleared while idle.
	always_ff @(posedge clk_i) begin
		t <= go_i ? t + 1 : 0;
	end
	// Boost low 7.5 us encloses precharge 4 us and sample 5 us; release 300 ns after sample.
	always_comb begin
		pix_o.reset = go_i && (t < 30 || t >= B + 760);
		pix_o.secondary_reset_ctl = go_i && t >= 20 && t < 260;
		pix_o.memory_boost_ctl_n = !(go_i && t >= B && t < B + 750);
		pix_o.precharge_n = !(go_i && t >= B + 10 && t < B + 410);
		pix_o.sample_n = !(go_i && t >= B + 220 && t < B + 720);
	end
endmodule : ctrl_model

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
// Self-checking bench: controller model on pixel pins, readout pins driven here.
module tb;
	logic                                clk = 1'b0;
	logic                                rst_n = 1'b0;
	logic                                go = 1'b0;
	logic                                seen_done = 1'b0;
	sensor_timing_pkg::pixel_pins_t      pix;
	sensor_timing_pkg::readout_pins_t    rd = 7'h02;
	sensor_timing_pkg::config_pins_t     cfg = '0;
	logic                                mem_hi, integ, rd_act, nl, col_pre, s1, s2, done;
	logic [1:0]                          lvl;
	logic [23:0]                         integ_cyc, overhead_cyc;
	logic [10:0]                         row;
	logic [11:0]                         a1, a2;
	int                                  errors = 0;
	int                                  total_checks = 0;
	int                                  stb1_cnt = 0;
	int                                  stb2_cnt = 0;
	int                                  nl_cnt = 0;
	// Settling delay before an address is judged; kept adjustable as output delay varies.
	localparam int                       SAMPLE_DLY = 8;
	// Clock of 100 MHz and a latch for the line end pulse.
	always #5 clk = ~clk;
	always @(posedge clk) if (done) seen_done <= 1'b1;
	// Counters of strobe and new line pulses, judged per scenario.
	always @(posedge clk) begin
		if (s1) stb1_cnt <= stb1_cnt + 1;
		if (s2) stb2_cnt <= stb2_cnt + 1;
		if (nl) nl_cnt <= nl_cnt + 1;
	end
	ctrl_model #(.INTEG(300)) i_ctrl_model (.clk_i(clk), .go_i(go), .pix_o(pix));
	sensor_timing i_sensor_timing (.CLK_I(clk), .RESETN_I(rst_n), .PIXEL_I(pix), .READOUT_I(rd),
		.CONFIG_I(cfg), .MEM_NODE_HIGH_O(mem_hi), .RESET_LEVEL_O(lvl), .INTEGRATING_O(integ),
		.INTEG_CYCLES_O(integ_cyc), .FRAME_OVERHEAD_CYCLES_O(overhead_cyc),
		.READOUT_ACTIVE_O(rd_act), .ROW_ADDR_O(row), .NEW_LINE_O(nl), .COL_PRECHARGE_O(col_pre),
		.PIX1_ADDR_O(a1),
		.PIX2_ADDR_O(a2), .PIX1_STB_O(s1), .PIX2_STB_O(s2), .LINE_DONE_O(done));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// Bounded wait for a level; running out counts as a mismatch.
	task automatic wait_for(ref logic s, input logic v);
		int n;
		for (n = 0; n < 3000 && s !== v; n++) @(posedge clk);
		if (n == 3000) `CHK(s, v)
	endtask : wait_for
	// One frame overhead with secondary reset overlapping the primary one.
	task automatic pixel_frame;
		go <= 1'b1;
		cyc(27);
		`CHK(lvl, sensor_timing_pkg::RST_LVL_PRIMARY)
		cyc(173);
		`CHK(lvl, sensor_timing_pkg::RST_LVL_SECONDARY)
		`CHK(integ, 1'b1)
		wait_for(integ, 1'b0);
		`CHK(integ_cyc, 24'(300 + 220))
		`CHK(mem_hi, 1'b0)
		wait_for(rd_act, 1'b1);
		`CHK(overhead_cyc, 24'h0002ee)
		`CHK(mem_hi, 1'b1)
		go <= 1'b0;
	endtask : pixel_frame
	// Row sync with a step edge inside it.
	task automatic ysync(input logic [9:0] start, input logic [10:0] exp);
		cfg.row_start <= start;
		cyc(6);
		rd.sync_y <= 1'b1;
		cyc(2);
		rd.clock_y <= 1'b1;
		cyc(8);
		`CHK(row, exp)
		rd.sync_y <= 1'b0;
		rd.clock_y <= 1'b0;
		cyc(10);
	endtask : ysync
	// Next line with row overhead pulses, then the 180 ns wait.
	task automatic ystep(input logic [10:0] exp);
		int base;
		base = nl_cnt;
		rd.clock_y <= 1'b1;
		rd.norowsel <= 1'b1;
		rd.pre_col_n <= 1'b0;
		cyc(8);
		`CHK(col_pre, 1'b1)
		rd.clock_y <= 1'b0;
		rd.norowsel <= 1'b0;
		rd.pre_col_n <= 1'b1;
		cyc(18);
		`CHK(row, exp)
		`CHK(nl_cnt - base, 1)
	endtask : ystep
	// One line of pixels in single or dual output mode.
	task automatic xline(input logic dual, input logic [9:0] start, input int edges);
		logic [11:0] exp;
		int          base1, base2, want, room;
		exp = {1'b0, start, 1'b0};
		base1 = stb1_cnt;
		base2 = stb2_cnt;
		want = dual ? 1 + edges / 2 : 1 + edges;
		room = (int'(sensor_timing_pkg::PIXELS_PER_LINE) - 2 * int'(start)) / (dual ? 2 : 1);
		if (want > room) want = room;
		cfg.dual_output <= dual;
		cfg.col_start <= start;
		rd.clock_x <= 1'b0;
		cyc(6);
		rd.sync_x <= 1'b1;
		rd.clock_x <= 1'b1;
		cyc(SAMPLE_DLY);
		rd.sync_x <= 1'b0;
		`CHK(a1, exp)
		for (int i = 0; i < edges; i++) begin
			rd.clock_x <= ~rd.clock_x;
			cyc(SAMPLE_DLY);
			if (!dual) exp = exp + 12'h001;
			else if (rd.clock_x) exp = exp + 12'h002;
			`CHK(a1, (exp > 12'h7ff) ? 12'h7ff : exp)
			if (dual) `CHK(a2, exp + 12'h001)
		end
		`CHK(stb1_cnt - base1, want)
		`CHK(stb2_cnt - base2, dual ? want : 0)
	endtask : xline
	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// Main sequence.
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		cyc(6);
		pixel_frame();
		ysync(10'h3ff, 11'h7fe);
		ystep(11'h7ff);
		ystep(11'h000);
		ysync(10'h001, 11'h002);
		xline(1'b0, 10'h005, 4);
		ystep(11'h003);
		xline(1'b1, 10'h000, 6);
		ystep(11'h004);
		xline(1'b0, 10'h3ff, 2);
		`CHK(seen_done, 1'b1)
		ystep(11'h005);
		rd.clock_x <= 1'b0;
		cyc(8);
		rd.clock_x <= 1'b1;
		cyc(8);
		`CHK(a1, 12'h7ff)
		stop_test();
	end
	// Watchdog against a hang.
	initial begin
		cyc(20000);
		errors++;
		$display("CHECK FAILED %0t watchdog", $time);
		stop_test();
	end
endmodule : tb
